// [bench/host_model.sv]
// host side model: hardware reset pin and whole serial write frames
// assumes sys_clk from the bench; pins change 1 ns after a rising edge
`timescale 1ns/1ps
module host_model (
  input  wire logic sys_clk,
  output logic      hwReset,
  output logic      serialPortSelect_n,
  output logic      serialClock,
  output logic      serialData
);
  // pins idle: reset low, deselected, clock still
  initial begin
    hwReset = 1'b0;
    serialPortSelect_n = 1'b1;
    serialClock = 1'b0;
    serialData = 1'b0;
  end
  // whole cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // low, high for 3 cycles, low again
  task automatic pulse_reset();
    tick(1);
    hwReset = 1'b1;
    tick(3);
    hwReset = 1'b0;
  endtask : pulse_reset
  // address then data, msb first, each phase held 5 cycles
  task automatic send(input logic [15:0] addr, input logic [7:0] data);
    logic [23:0] frame;
    frame = {addr, data};
    tick(1);
    serialPortSelect_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serialData = frame[i];
      tick(5);
      serialClock = 1'b1;
      tick(5);
      serialClock = 1'b0;
      tick(5);
    end
    serialPortSelect_n = 1'b1;
    serialData = ~frame[0]; // released line does not keep the last bit
    tick(6);
  endtask : send
endmodule : host_model

// [bench/testbench.sv]
// self-checking bench for the start-up configuration logic
// assumes host_model drives all pins; sys_clk 125 MHz
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic       sys_clk, rst_n, hwReset, serialPortSelect_n, serialClock, serialData;
  logic       fourLane, pllTwo, mismatch, mfOverride, highPass, laneOrder, unlocked;
  logic       masterSel, perfBit, anaPulse, linkPulse, commit, strobe, ready;
  logic [1:0] page;
  int         n_mismatch, compares, nAna, nLink, nCommit, nWr, cycles, n0;

  host_model i_host (.sys_clk(sys_clk), .hwReset(hwReset),
    .serialPortSelect_n(serialPortSelect_n), .serialClock(serialClock),
    .serialData(serialData));
  adc_startup_config_sequence i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hwReset(hwReset),
    .serialPortSelect_n(serialPortSelect_n), .serialClock(serialClock),
    .serialData(serialData), .fourLaneSerialization(fourLane), .linkPllTwoLane(pllTwo),
    .modeMismatch(mismatch), .multiframeOverride(mfOverride), .highPassFilter(highPass),
    .laneOrderCorrect(laneOrder), .filterUnlocked(unlocked), .masterPageSelected(masterSel),
    .performanceBitSet(perfBit), .selectedPage(page), .analogResetPulse(anaPulse),
    .linkBankSoftReset(linkPulse), .commitPulse(commit), .writeStrobe(strobe),
    .configReady(ready));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // pulse counters and hang limit
  always @(posedge sys_clk) begin
    cycles++;
    if (anaPulse === 1'b1) nAna++;
    if (linkPulse === 1'b1) nLink++;
    if (commit === 1'b1) nCommit++;
    if (strobe === 1'b1) nWr++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // counts and verdict
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // one write, then let pins and registers settle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int s0;
    s0 = nWr;
    i_host.send(a, d);
    i_host.tick(10);
    `CHK("strobe", s0 + 1, nWr)
  endtask : wr
  // link bank page select pair
  task automatic sel(input logic [7:0] v);
    wr(16'h4003, 8'h00);
    wr(16'h4004, v);
  endtask : sel
  // bounded wait for the write guard
  task automatic wait_ready();
    for (int i = 0; i < 40 && ready !== 1'b1; i++) i_host.tick(1);
    `CHK("ready", 1'b1, ready)
  endtask : wait_ready
  // defaults after reset, page select, analog bank
  task automatic t_basic();
    logic [7:0] pv[3];
    pv = '{8'h68, 8'h69, 8'h6a};
    `CHK("fourLane", 1'b1, fourLane)
    `CHK("highPass", 1'b0, highPass)
    `CHK("page", 2'h0, page)
    wait_ready();
    for (int i = 0; i < 3; i++) begin
      sel(pv[i]);
      `CHK("page", 2'(i + 1), page)
    end
    wr(16'h0011, 8'h80);
    `CHK("masterSel", 1'b1, masterSel)
    wr(16'h0059, 8'h20);
    `CHK("perfBit", 1'b1, perfBit)
    n0 = nAna;
    wr(16'h0000, 8'h81);
    `CHK("anaPulse", n0 + 1, nAna)
    `CHK("masterSel", 1'b0, masterSel)
    `CHK("perfBit", 1'b0, perfBit)
    wr(16'h4001, 8'h00);
    wr(16'h4002, 8'h00);
    `CHK("page", 2'h3, page)
    $display("test basic done");
  endtask : t_basic
  // lane mode, PLL, filter, commit, link reset
  task automatic t_link();
    sel(8'h69);
    wr(16'h6000, 8'h80);
    `CHK("mfOverride", 1'b1, mfOverride)
    wr(16'h6001, 8'h02);
    `CHK("fourLane", 1'b0, fourLane)
    `CHK("mismatch", 1'b1, mismatch)
    sel(8'h6a);
    wr(16'h6016, 8'h02);
    `CHK("pllTwo", 1'b1, pllTwo)
    `CHK("mismatch", 1'b0, mismatch)
    wr(16'h6016, 8'h00);
    `CHK("pllTwo", 1'b0, pllTwo)
    `CHK("mismatch", 1'b1, mismatch)
    sel(8'h68);
    wr(16'h6052, 8'h80);
    wr(16'h6072, 8'h08);
    wr(16'h604d, 8'h08);
    `CHK("unlocked", 1'b1, unlocked)
    wr(16'h6041, 8'h16);
    `CHK("highPass", 1'b0, highPass)
    n0 = nCommit;
    wr(16'h6000, 8'h01);
    wr(16'h6000, 8'h00);
    `CHK("commit", n0 + 1, nCommit)
    `CHK("highPass", 1'b1, highPass)
    `CHK("laneOrder", 1'b1, laneOrder)
    n0 = nLink;
    wr(16'h60f7, 8'h01);
    `CHK("linkPulse", n0 + 1, nLink)
    `CHK("fourLane", 1'b1, fourLane)
    `CHK("highPass", 1'b0, highPass)
    `CHK("mfOverride", 1'b0, mfOverride)
    wr(16'h6041, 8'h16);
    wr(16'h6000, 8'h01);
    wr(16'h6000, 8'h00);
    `CHK("highPass", 1'b0, highPass)
    `CHK("laneOrder", 1'b0, laneOrder)
    $display("test link done");
  endtask : t_link
  // hardware reset pin restores defaults
  task automatic t_hwreset();
    wr(16'h0011, 8'h80);
    `CHK("masterSel", 1'b1, masterSel)
    i_host.pulse_reset();
    i_host.tick(8);
    `CHK("ready", 1'b0, ready)
    `CHK("masterSel", 1'b0, masterSel)
    `CHK("page", 2'h0, page)
    wait_ready();
    $display("test hwreset done");
  endtask : t_hwreset
  // main sequence
  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    i_host.tick(2);
    t_basic();
    t_link();
    t_hwreset();
    close_out();
  end
endmodule : testbench

// [include/adc_cfg_pkg.sv]
// constants and types for the converter start-up configuration logic
// assumes a 125 MHz system clock and a 24-bit serial write frame
package adc_cfg_pkg;

  // clock and timing
  localparam int CLK_PERIOD_PS      = 8000;
  localparam int T_RESET_PULSE_NS   = 10;   // least hardware reset pulse
  localparam int T_WRITE_DELAY_NS   = 100;  // least delay from reset release to select
  localparam int RESET_PULSE_CYCLES =
    (T_RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_DELAY_INT    =
    (T_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GUARD_W            = 4;
  localparam logic [GUARD_W-1:0] WRITE_DELAY_CYCLES = GUARD_W'(WRITE_DELAY_INT);

  // serial frame: 16 address bits then 8 data bits, msb first
  localparam int FRAME_BITS = 24;
  localparam int COUNT_W    = 5;
  localparam logic [COUNT_W-1:0] FRAME_LAST = COUNT_W'(FRAME_BITS);

  // register addresses, bank nibble in bits 15:12
  localparam logic [15:0] ADDR_GENERAL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_MASTER_SEL    = 16'h0011;
  localparam logic [15:0] ADDR_PERF_MODE     = 16'h0059;
  localparam logic [15:0] ADDR_PAGE_LOW      = 16'h4003;
  localparam logic [15:0] ADDR_PAGE_HIGH     = 16'h4004;
  localparam logic [15:0] ADDR_PAGE_CTRL     = 16'h6000;
  localparam logic [15:0] ADDR_LANE_MODE     = 16'h6001;
  localparam logic [15:0] ADDR_PLL_MODE      = 16'h6016;
  localparam logic [15:0] ADDR_LINK_RESET    = 16'h60f7;
  localparam logic [15:0] ADDR_LANE_ORDER0   = 16'h6052;
  localparam logic [15:0] ADDR_LANE_ORDER1   = 16'h6072;
  localparam logic [15:0] ADDR_FILTER_UNLOCK = 16'h604d;
  localparam logic [15:0] ADDR_FILTER_SEL    = 16'h6041;

  // data values
  localparam logic [7:0] SOFT_RESET_VAL   = 8'h81;
  localparam logic [7:0] MASTER_SEL_VAL   = 8'h80;
  localparam logic [7:0] PAGE_LOW_VAL     = 8'h00;
  localparam logic [7:0] PAGE_MAIN_VAL    = 8'h68;
  localparam logic [7:0] PAGE_LINKDIG_VAL = 8'h69;
  localparam logic [7:0] PAGE_LINKANA_VAL = 8'h6a;
  localparam logic [7:0] MODE_FOUR_VAL    = 8'h01;
  localparam logic [7:0] MODE_TWO_VAL     = 8'h02;
  localparam logic [7:0] PLL_FOUR_VAL     = 8'h00;
  localparam logic [7:0] PLL_TWO_VAL      = 8'h02;
  localparam logic [7:0] LANE_ORDER0_VAL  = 8'h80;
  localparam logic [7:0] LANE_ORDER1_VAL  = 8'h08;
  localparam logic [7:0] FILTER_UNLOCK_VAL = 8'h08;
  localparam logic [7:0] FILTER_LOW_VAL   = 8'h12;
  localparam logic [7:0] FILTER_HIGH_VAL  = 8'h16;

  // field positions
  localparam int SELF_CLEAR_BIT = 0;
  localparam int COMMIT_BIT     = 0;
  localparam int K_OVERRIDE_BIT = 7;
  localparam int ALWAYS_ONE_BIT = 5;

  // values after reset
  localparam logic [7:0] RST_PAGE_LOW    = 8'h00;
  localparam logic [7:0] RST_LANE_ORDER  = 8'h00;
  localparam logic       RST_TWO_LANE    = 1'b0;  // four lanes after reset
  localparam logic       RST_HIGH_PASS   = 1'b0;  // low-pass after reset

  typedef enum logic [1:0] {PAGE_NONE, PAGE_MAIN_DIG, PAGE_LINK_DIG, PAGE_LINK_ANA} page_type;
  typedef enum logic [1:0] {FRAME_IDLE, FRAME_SHIFT, FRAME_WAIT} frame_type;

endpackage : adc_cfg_pkg

// [rtl/adc_startup_config_sequence.sv]
// converter configuration registers behind the serial control port
// assumes a host drives reset, select, clock and data pins slowly against sys_clk
//
// Behaviour
// R01 - host waits 1 ms after supplies
// R02 - host holds reset high at least 10 ns
// R03 - host waits 100 ns before selecting
// R04 - hardware reset restores every default
// R05 - 81h to 0-000h resets analog bank, self-clears
// R06 - host clears unused link bank pages
// R07 - 4-004h value selects the link bank page
// R08 - 01h to 6-0F7h resets link bank
// R09 - commit pulse applies main digital settings
// R10 - 80h to 0-011h selects master page
// R11 - host sets always-one performance bit
// R12 - 80h sets multiframe length override
// R13 - 6-001h picks four or two lanes
// R14 - 6-016h picks matching link PLL setting
// R15 - four-lane serialization after any reset; the 81h analog bank reset at 0-000h leaves the lane mode as it was
// R16 - host writes lane order values
// R17 - 08h to 6-04Dh unlocks filter choice
// R18 - 6-041h picks low or high pass
// R19 - host sequences I/O supply first
// R20 - host sends each write whole, in order
`timescale 1ns/1ps
module adc_startup_config_sequence (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       hwReset,
  input  wire logic       serialPortSelect_n,
  input  wire logic       serialClock,
  input  wire logic       serialData,
  output logic            fourLaneSerialization,
  output logic            linkPllTwoLane,
  output logic            modeMismatch,
  output logic            multiframeOverride,
  output logic            highPassFilter,
  output logic            laneOrderCorrect,
  output logic            filterUnlocked,
  output logic            masterPageSelected,
  output logic            performanceBitSet,
  output logic [1:0]      selectedPage,
  output logic            analogResetPulse,
  output logic            linkBankSoftReset,
  output logic            commitPulse,
  output logic            writeStrobe,
  output logic            configReady
);

  typedef struct packed {
    adc_cfg_pkg::frame_type          frame;
    logic [adc_cfg_pkg::COUNT_W-1:0] bitCount;
    logic [23:0]                     shift;
    logic                            sclkPrev;
    logic                            senPrev;
    logic [adc_cfg_pkg::GUARD_W-1:0] guard;
    logic                            wrValid;
    logic [15:0]                     wrAddr;
    logic [7:0]                      wrData;
    logic                            masterSel;
    logic                            perfAlwaysOne;
    logic [7:0]                      pageLow;
    adc_cfg_pkg::page_type           page;
    logic                            kOverride;
    logic                            modeTwoLane;
    logic                            fourLane;
    logic                            pllTwoLane;
    logic [7:0]                      laneOrder0;
    logic [7:0]                      laneOrder1;
    logic                            filterUnlock;
    logic                            stagedHighPass;
    logic                            commitBit;
    logic                            activeHighPass;
    logic                            activeLaneOrder;
    logic                            analogResetPulse;
    logic                            linkResetPulse;
    logic                            commitPulse;
    logic                            mismatch;
    logic                            ready;
  } state_type;

  state_type st;
  state_type next_st;
  logic      hwLvl;
  logic      senLvl;
  logic      sclkLvl;
  logic      sdataLvl;

  // every pin passes the agreement synchroniser; a 2-cycle reset pulse is seen
  pin_sync #(.RESET_LEVEL(1'b0)) u_sync_reset (.sys_clk(sys_clk), .rst_n(rst_n),  // R02
    .pinIn(hwReset), .level(hwLvl));
  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_sen (.sys_clk(sys_clk), .rst_n(rst_n),
    .pinIn(serialPortSelect_n), .level(senLvl));
  pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (.sys_clk(sys_clk), .rst_n(rst_n),
    .pinIn(serialClock), .level(sclkLvl));
  pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sdata (.sys_clk(sys_clk), .rst_n(rst_n),
    .pinIn(serialData), .level(sdataLvl));

  // default contents of every configuration register
  function automatic state_type reset_state();
    state_type s;
    s              = '0;
    s.frame        = adc_cfg_pkg::FRAME_IDLE;
    s.sclkPrev     = 1'b0;
    s.senPrev      = 1'b1;
    s.guard        = adc_cfg_pkg::WRITE_DELAY_CYCLES;
    s.pageLow      = adc_cfg_pkg::RST_PAGE_LOW;
    s.page         = adc_cfg_pkg::PAGE_NONE;
    s.modeTwoLane  = adc_cfg_pkg::RST_TWO_LANE;   // R15
    s.pllTwoLane   = adc_cfg_pkg::RST_TWO_LANE;   // R15
    s.fourLane     = !adc_cfg_pkg::RST_TWO_LANE;  // R15
    s.laneOrder0   = adc_cfg_pkg::RST_LANE_ORDER;
    s.laneOrder1   = adc_cfg_pkg::RST_LANE_ORDER;
    s.stagedHighPass = adc_cfg_pkg::RST_HIGH_PASS;
    s.activeHighPass = adc_cfg_pkg::RST_HIGH_PASS;
    return s;
  endfunction : reset_state

  // frame capture, register decode and commit logic
  always_comb begin
    next_st                  = st;
    next_st.wrValid          = 1'b0;
    next_st.analogResetPulse = 1'b0;
    next_st.linkResetPulse   = 1'b0;
    next_st.commitPulse      = 1'b0;
    next_st.sclkPrev         = sclkLvl;
    next_st.senPrev          = senLvl;
    if (st.guard != '0) begin
      next_st.guard = st.guard - adc_cfg_pkg::GUARD_W'(1);  // R03
    end

    // serial frame: start on select fall, shift on clock rise, abort on early rise
    case (st.frame)
      adc_cfg_pkg::FRAME_IDLE: begin
        if (st.senPrev && !senLvl && st.guard == '0) begin  // R03
          next_st.frame    = adc_cfg_pkg::FRAME_SHIFT;
          next_st.bitCount = '0;
        end
      end
      adc_cfg_pkg::FRAME_SHIFT: begin
        if (senLvl) begin
          next_st.frame = adc_cfg_pkg::FRAME_IDLE;  // R20
        end else if (sclkLvl && !st.sclkPrev) begin
          next_st.shift    = {st.shift[22:0], sdataLvl};
          next_st.bitCount = st.bitCount + adc_cfg_pkg::COUNT_W'(1);
          if (next_st.bitCount == adc_cfg_pkg::FRAME_LAST) begin
            next_st.frame   = adc_cfg_pkg::FRAME_WAIT;
            next_st.wrValid = 1'b1;
            next_st.wrAddr  = next_st.shift[23:8];
            next_st.wrData  = next_st.shift[7:0];
          end
        end
      end
      adc_cfg_pkg::FRAME_WAIT: begin
        if (senLvl) begin
          next_st.frame = adc_cfg_pkg::FRAME_IDLE;  // extra clocks ignored
        end
      end
      default: begin
        next_st.frame = adc_cfg_pkg::FRAME_IDLE;
      end
    endcase

    // apply the captured write
    if (st.wrValid) begin
      case (st.wrAddr)
        adc_cfg_pkg::ADDR_GENERAL_RESET: begin
          if (st.wrData == adc_cfg_pkg::SOFT_RESET_VAL) begin
            next_st.masterSel        = 1'b0;  // R05
            next_st.perfAlwaysOne    = 1'b0;  // R05
            next_st.analogResetPulse = 1'b1;  // R05
          end
        end
        adc_cfg_pkg::ADDR_MASTER_SEL: begin
          next_st.masterSel = (st.wrData == adc_cfg_pkg::MASTER_SEL_VAL);  // R10
        end
        adc_cfg_pkg::ADDR_PERF_MODE: begin
          if (st.masterSel) begin
            next_st.perfAlwaysOne = st.wrData[adc_cfg_pkg::ALWAYS_ONE_BIT];
          end
        end
        adc_cfg_pkg::ADDR_PAGE_LOW: begin
          next_st.pageLow = st.wrData;
        end
        adc_cfg_pkg::ADDR_PAGE_HIGH: begin
          next_st.page = adc_cfg_pkg::PAGE_NONE;  // R07
          if (st.pageLow == adc_cfg_pkg::PAGE_LOW_VAL) begin
            case (st.wrData)
              adc_cfg_pkg::PAGE_MAIN_VAL:    next_st.page = adc_cfg_pkg::PAGE_MAIN_DIG;  // R07
              adc_cfg_pkg::PAGE_LINKDIG_VAL: next_st.page = adc_cfg_pkg::PAGE_LINK_DIG;  // R07
              adc_cfg_pkg::PAGE_LINKANA_VAL: next_st.page = adc_cfg_pkg::PAGE_LINK_ANA;  // R07
              default:                       next_st.page = adc_cfg_pkg::PAGE_NONE;
            endcase
          end
        end
        default: begin
          // page-mapped writes handled below
        end
      endcase

      // main digital page
      if (st.page == adc_cfg_pkg::PAGE_MAIN_DIG) begin
        case (st.wrAddr)
          adc_cfg_pkg::ADDR_LINK_RESET: begin
            if (st.wrData[adc_cfg_pkg::SELF_CLEAR_BIT]) begin
              next_st.kOverride       = 1'b0;  // R08
              next_st.modeTwoLane     = adc_cfg_pkg::RST_TWO_LANE;  // R08
              next_st.pllTwoLane      = adc_cfg_pkg::RST_TWO_LANE;  // R08
              next_st.laneOrder0      = adc_cfg_pkg::RST_LANE_ORDER;
              next_st.laneOrder1      = adc_cfg_pkg::RST_LANE_ORDER;
              next_st.filterUnlock    = 1'b0;
              next_st.stagedHighPass  = adc_cfg_pkg::RST_HIGH_PASS;
              next_st.activeHighPass  = adc_cfg_pkg::RST_HIGH_PASS;
              next_st.activeLaneOrder = 1'b0;
              next_st.commitBit       = 1'b0;
              next_st.linkResetPulse  = 1'b1;  // R08
            end
          end
          adc_cfg_pkg::ADDR_PAGE_CTRL: begin
            next_st.commitBit = st.wrData[adc_cfg_pkg::COMMIT_BIT];
            if (st.commitBit && !next_st.commitBit) begin
              next_st.activeHighPass  = st.stagedHighPass;  // R09
              next_st.activeLaneOrder = (st.laneOrder0 == adc_cfg_pkg::LANE_ORDER0_VAL) &&
                                        (st.laneOrder1 == adc_cfg_pkg::LANE_ORDER1_VAL);  // R09
              next_st.commitPulse     = 1'b1;  // R09
            end
          end
          adc_cfg_pkg::ADDR_LANE_ORDER0: next_st.laneOrder0 = st.wrData;
          adc_cfg_pkg::ADDR_LANE_ORDER1: next_st.laneOrder1 = st.wrData;
          adc_cfg_pkg::ADDR_FILTER_UNLOCK: begin
            next_st.filterUnlock = (st.wrData == adc_cfg_pkg::FILTER_UNLOCK_VAL);  // R17
          end
          adc_cfg_pkg::ADDR_FILTER_SEL: begin
            if (st.filterUnlock) begin  // R17
              if (st.wrData == adc_cfg_pkg::FILTER_LOW_VAL) begin
                next_st.stagedHighPass = 1'b0;  // R18
              end else if (st.wrData == adc_cfg_pkg::FILTER_HIGH_VAL) begin
                next_st.stagedHighPass = 1'b1;  // R18
              end
            end
          end
          default: begin
          end
        endcase
      end

      // link digital page
      if (st.page == adc_cfg_pkg::PAGE_LINK_DIG) begin
        if (st.wrAddr == adc_cfg_pkg::ADDR_PAGE_CTRL) begin
          next_st.kOverride = st.wrData[adc_cfg_pkg::K_OVERRIDE_BIT];  // R12
        end else if (st.wrAddr == adc_cfg_pkg::ADDR_LANE_MODE) begin
          if (st.wrData == adc_cfg_pkg::MODE_FOUR_VAL) begin
            next_st.modeTwoLane = 1'b0;  // R13
          end else if (st.wrData == adc_cfg_pkg::MODE_TWO_VAL) begin
            next_st.modeTwoLane = 1'b1;  // R13
          end
        end
      end

      // link analog page
      if (st.page == adc_cfg_pkg::PAGE_LINK_ANA && st.wrAddr == adc_cfg_pkg::ADDR_PLL_MODE) begin
        if (st.wrData == adc_cfg_pkg::PLL_FOUR_VAL) begin
          next_st.pllTwoLane = 1'b0;  // R14
        end else if (st.wrData == adc_cfg_pkg::PLL_TWO_VAL) begin
          next_st.pllTwoLane = 1'b1;  // R14
        end
      end
    end

    next_st.fourLane = !next_st.modeTwoLane;  // R15
    next_st.mismatch = next_st.modeTwoLane != next_st.pllTwoLane;  // R14
    next_st.ready    = (next_st.guard == '0);
    if (hwLvl) begin
      next_st = reset_state();  // R04
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  assign fourLaneSerialization = st.fourLane;
  assign linkPllTwoLane        = st.pllTwoLane;
  assign modeMismatch          = st.mismatch;
  assign multiframeOverride    = st.kOverride;
  assign highPassFilter        = st.activeHighPass;
  assign laneOrderCorrect      = st.activeLaneOrder;
  assign filterUnlocked        = st.filterUnlock;
  assign masterPageSelected    = st.masterSel;
  assign performanceBitSet     = st.perfAlwaysOne;
  assign selectedPage          = st.page;
  assign analogResetPulse      = st.analogResetPulse;
  assign linkBankSoftReset     = st.linkResetPulse;
  assign commitPulse           = st.commitPulse;
  assign writeStrobe           = st.wrValid;
  assign configReady           = st.ready;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || hwLvl);

  hw_defaults_a: assert property (disable iff (!rst_n) hwLvl |=> // R04
      (st.page == adc_cfg_pkg::PAGE_NONE && !st.activeHighPass && !st.masterSel))
    else $error("hardware reset left a register off default");
  four_lane_a: assert property (disable iff (!rst_n) hwLvl |=> // R15
      (fourLaneSerialization && !linkPllTwoLane && !modeMismatch))
    else $error("not four-lane after reset");
  soft_reset_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_GENERAL_RESET && // R05
      st.wrData == adc_cfg_pkg::SOFT_RESET_VAL |=> (analogResetPulse && !st.masterSel) ##1
      !analogResetPulse)
    else $error("analog soft reset wrong or not self-clearing");
  page_sel_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_PAGE_HIGH && // R07
      st.pageLow == adc_cfg_pkg::PAGE_LOW_VAL && st.wrData == adc_cfg_pkg::PAGE_LINKDIG_VAL
      |=> st.page == adc_cfg_pkg::PAGE_LINK_DIG)
    else $error("link digital page not selected");
  link_reset_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_LINK_RESET && // R08
      st.wrData[adc_cfg_pkg::SELF_CLEAR_BIT] && st.page == adc_cfg_pkg::PAGE_MAIN_DIG
      |=> (linkBankSoftReset && !st.modeTwoLane && !st.kOverride) ##1 !linkBankSoftReset)
    else $error("link bank reset wrong or not self-clearing");
  commit_apply_a: assert property ($fell(st.commitBit) && !st.linkResetPulse |-> // R09
      (st.commitPulse && st.activeHighPass == $past(st.stagedHighPass)))
    else $error("commit did not apply staged filter");
  commit_hold_a: assert property (!st.commitPulse && !st.linkResetPulse && !$past(hwLvl) // R09
      |-> $stable(st.activeHighPass) && $stable(st.activeLaneOrder))
    else $error("main digital setting changed without commit");
  master_sel_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_MASTER_SEL && // R10
      st.wrData == adc_cfg_pkg::MASTER_SEL_VAL |=> masterPageSelected)
    else $error("master page not selected");
  k_override_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_PAGE_CTRL && // R12
      st.page == adc_cfg_pkg::PAGE_LINK_DIG && st.wrData[adc_cfg_pkg::K_OVERRIDE_BIT]
      |=> multiframeOverride)
    else $error("multiframe override not set");
  lane_mode_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_LANE_MODE && // R13
      st.page == adc_cfg_pkg::PAGE_LINK_DIG && st.wrData == adc_cfg_pkg::MODE_TWO_VAL
      |=> !fourLaneSerialization)
    else $error("two-lane mode not taken");
  pll_mode_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_PLL_MODE && // R14
      st.page == adc_cfg_pkg::PAGE_LINK_ANA && st.wrData == adc_cfg_pkg::PLL_TWO_VAL
      |=> linkPllTwoLane && (modeMismatch == fourLaneSerialization))
    else $error("pll setting or mismatch flag wrong");
  filter_lock_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_FILTER_SEL && // R17
      !st.filterUnlock |=> $stable(st.stagedHighPass))
    else $error("filter changed while locked");
  filter_sel_a: assert property (st.wrValid && st.wrAddr == adc_cfg_pkg::ADDR_FILTER_SEL && // R18
      st.filterUnlock && st.page == adc_cfg_pkg::PAGE_MAIN_DIG &&
      st.wrData == adc_cfg_pkg::FILTER_HIGH_VAL |=> st.stagedHighPass)
    else $error("high-pass not staged");
  write_guard_a: assert property (disable iff (!rst_n) $past(hwLvl) && !hwLvl |-> // R03
      (st.guard == adc_cfg_pkg::WRITE_DELAY_CYCLES && !configReady && st.frame == adc_cfg_pkg::FRAME_IDLE))
    else $error("write guard not loaded at reset release");
  frame_len_a: assert property (st.wrValid |-> // R20
      (st.bitCount == adc_cfg_pkg::FRAME_LAST && st.frame == adc_cfg_pkg::FRAME_WAIT))
    else $error("write taken from incomplete frame");

endmodule : adc_startup_config_sequence

// [rtl/pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_type;

  sync_type st;
  sync_type next_st;

  // level follows only once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule : pin_sync
